// *** include/alu_defines.svh ***
// alu_defines.svh: register map, field positions, reset values and timing
// assumes classic wishbone with 32-bit data and byte addresses
// Function
// - 16-bit datapath doing add, subtract, shifts and bitwise logic.
// - arithmetic operands are two's complement unless stated otherwise.
// - carry, zero, negative, overflow and digit carry flags track the op.
// - on subtract, carry means no borrow and digit carry no digit borrow.
// - each operation except divide runs at byte or word width, per its size mode; divides are word only.
// - operands come from the operand registers; results go to quotient_reg and remainder_reg.
// - 17x17 multiplier: signed, unsigned and mixed-sign word products.
// - multiply a signed or unsigned word by an unsigned 5-bit literal.
// - unsigned byte by byte multiply mode.
// - signed and unsigned 32/16 and 16/16 divide.
// - quotient lands in quotient_reg, remainder in remainder_reg.
// - one iteration per divisor bit, so both divide sizes take equal time.
// - single-cycle arithmetic right or left shift by up to 15.
// - multi-bit shifts read and write working registers only.
// - shifts: arithmetic right, left and logical right by one or more.
// - every divide takes 19 cycles and can be abandoned at any cycle.
// - every multiply completes in one cycle.
// - digit carry is carry out of bit 3 (byte) or bit 7 (word).
// - overflow is set on signed add/subtract overflow or on divide overflow, and cleared otherwise by those ops.
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH
`define ALU_OFS_OPA_LO 8'h00
`define ALU_OFS_OPA_HI 8'h04
`define ALU_OFS_OPB 8'h08
`define ALU_OFS_CTRL 8'h0C
`define ALU_OFS_RES_LO 8'h10
`define ALU_OFS_RES_HI 8'h14
`define ALU_OFS_STAT 8'h18
`define ALU_CTRL_BYTE 8
`define ALU_CTRL_LIT 16
`define ALU_CTRL_ABORT 31
`define ALU_STAT_BUSY 16
`define ALU_ST_CARRY 0
`define ALU_ST_ZERO 1
`define ALU_ST_OVF 2
`define ALU_ST_NEG 3
`define ALU_ST_HALF 8
`define ALU_ST_WMASK 16'h010F
`define ALU_RST_WORD 16'h0000
`define ALU_DIV_BITS 16
`define ALU_DIV_CYCLES 19
`endif

// *** include/alu_pkg.sv ***
// alu_pkg.sv: types shared by the alu block
// assumes alu_defines.svh supplies every number
`default_nettype none
package alu_pkg;
    typedef enum logic [4:0] {
        op_add, op_addc, op_sub, op_subb, op_and, op_ior, op_xor,
        arith_right_shift, left_shift_op, logical_right_shift,
        op_mul_ss, op_mul_uu, op_mul_us, op_mul_sl, op_mul_ul,
        op_div_s32, op_div_u32, op_div_s16, op_div_u16
    } alu_op_t;
endpackage : alu_pkg
`default_nettype wire

// *** hw/alu_mul.sv ***
// alu_mul.sv: combinational 17x17 signed multiplier core
// assumes the caller picks the sign of each operand by a_sgn and b_sgn
`timescale 1ns/100ps
`default_nettype none
module alu_mul #(
    parameter int W = 16
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic a_sgn,
    input wire logic b_sgn,
    output logic [2*W-1:0] prod
);
    logic signed [W:0] ea;
    logic signed [W:0] eb;
    logic signed [2*W+1:0] full;

    // the extra top bit lets every sign mix share one signed array
    assign ea = {a_sgn & a[W-1], a};
    assign eb = {b_sgn & b[W-1], b};
    assign full = ea * eb;
    assign prod = full[2*W-1:0];
endmodule : alu_mul
`default_nettype wire

// *** hw/alu_div.sv ***
// alu_div.sv: iterative divider, one quotient bit per cycle
// assumes start is a one-cycle pulse and operands hold for that cycle
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.svh"
module alu_div #(
    parameter int W = `ALU_DIV_BITS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic abort,
    input wire logic sgn,
    input wire logic [2*W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic ovf,
    output logic [W-1:0] quo,
    output logic [W-1:0] rem
);
    localparam int CW = $clog2(W + 3);
    localparam logic [CW-1:0] ITER = CW'(W);
    localparam logic [CW-1:0] FIX = CW'(W + 1);
    localparam logic [CW-1:0] LAST = CW'(W + 2);
    logic [CW-1:0] cnt;
    logic [W-1:0] pr, q, d, dm;
    logic [2*W-1:0] mag;
    logic [W:0] tr;
    logic neg_q, neg_r;

    always_comb begin
        mag = (sgn && dividend[2*W-1]) ? -dividend : dividend;
        dm = (sgn && divisor[W-1]) ? -divisor : divisor;
        tr = {pr, q[W-1]};
    end

    always_ff @(posedge clk) begin
        if (srst || abort) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                cnt <= CW'(1);
            end else if (busy) begin
                cnt <= cnt + CW'(1);
                if (cnt == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    cnt <= '0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (start && !busy) begin
            pr <= mag[2*W-1:W];
            q <= mag[W-1:0];
            d <= dm;
            neg_q <= sgn & (dividend[2*W-1] ^ divisor[W-1]);
            neg_r <= sgn & dividend[2*W-1];
            ovf <= (dm == '0) || (mag[2*W-1:W] >= dm);
        end else if (busy && cnt <= ITER) begin
            if (tr >= {1'b0, d}) begin
                pr <= W'(tr - {1'b0, d});
                q <= {q[W-2:0], 1'b1};
            end else begin
                pr <= tr[W-1:0];
                q <= {q[W-2:0], 1'b0};
            end
        end else if (busy && cnt == FIX) begin
            quo <= neg_q ? -q : q;
            rem <= neg_r ? -pr : pr;
            if (neg_q ? (q > {1'b1, {(W-1){1'b0}}}) : (sgn && q[W-1])) begin
                ovf <= 1'b1;
            end
        end
    end

    div_latency_a: assert property (@(posedge clk)
        disable iff (srst || abort) start && !busy |-> ##19 done)
        else $error("divide did not finish in 19 cycles");
    div_zero_a: assert property (@(posedge clk)
        disable iff (srst || abort)
        start && !busy && divisor == '0 |-> ##19 (done && ovf))
        else $error("divide by zero not flagged");
endmodule : alu_div
`default_nettype wire

// *** hw/alu_top.sv ***
// alu_top.sv: 16-bit alu with multiplier, divider and barrel shifter
// reached as a classic wishbone slave, one 32-bit word per register
// assumes one 50 MHz clock and a synchronous active-high reset
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.svh"
module alu_top
    import alu_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [15:0] alu_status_reg
);
    logic [31:0] dividend_reg_pair;
    logic [15:0] divisor_reg;
    logic [15:0] quotient_reg;
    logic [15:0] remainder_reg;
    alu_op_t op_code;
    logic byte_mode;
    logic [4:0] lit5;
    logic go;
    logic div_abort;
    logic req;
    logic wr_commit;
    logic ctrl_wr;
    logic [31:0] rd_mux;
    logic [15:0] opnd_a, opnd_b, bx, sx, zx, shf, val, res_lo;
    logic [15:0] mul_a, mul_b, next_status;
    logic [31:0] prod;
    logic [16:0] sum_w;
    logic [8:0] sum_b;
    logic [4:0] sum_n;
    logic [3:0] amt;
    logic cin, is_sub, is_div, wide_div, sgn_div, mul_a_sgn, mul_b_sgn;
    logic wr_hi, upd_arith, upd_nz, car, dcar, ovf, neg, zero;
    logic div_start, div_busy, div_done, div_ovf;
    logic [15:0] div_q, div_r;
    logic [31:0] div_dvd;

    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [15:0] nw,
        input logic [1:0] sel
    );
        lane_merge = old;
        if (sel[0]) begin
            lane_merge[7:0] = nw[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = nw[15:8];
        end
    endfunction : lane_merge

    // bus slave: ack one cycle after the request, writes land on the ack edge
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_commit = req && wb_we_i && wb_ack_o;
    assign ctrl_wr = wr_commit && (wb_adr_i == `ALU_OFS_CTRL);

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    always_comb begin
        case (wb_adr_i)
            `ALU_OFS_OPA_LO: rd_mux = {16'h0000, dividend_reg_pair[15:0]};
            `ALU_OFS_OPA_HI: rd_mux = {16'h0000, dividend_reg_pair[31:16]};
            `ALU_OFS_OPB: rd_mux = {16'h0000, divisor_reg};
            `ALU_OFS_CTRL: rd_mux = {11'h000, lit5, 7'h00, byte_mode,
                3'h0, op_code};
            `ALU_OFS_RES_LO: rd_mux = {16'h0000, quotient_reg};
            `ALU_OFS_RES_HI: rd_mux = {16'h0000, remainder_reg};
            `ALU_OFS_STAT: rd_mux = {15'h0000, div_busy, alu_status_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= rd_mux;
        end
    end

    // operand words are frozen while a divide runs
    always_ff @(posedge clk) begin
        if (srst) begin
            dividend_reg_pair <= 32'h00000000;
            divisor_reg <= `ALU_RST_WORD;
        end else if (wr_commit && !div_busy) begin
            if (wb_adr_i == `ALU_OFS_OPA_LO) begin
                dividend_reg_pair[15:0] <= lane_merge(
                    dividend_reg_pair[15:0], wb_dat_i[15:0], wb_sel_i[1:0]);
            end
            if (wb_adr_i == `ALU_OFS_OPA_HI) begin
                dividend_reg_pair[31:16] <= lane_merge(
                    dividend_reg_pair[31:16], wb_dat_i[15:0], wb_sel_i[1:0]);
            end
            if (wb_adr_i == `ALU_OFS_OPB) begin
                divisor_reg <= lane_merge(divisor_reg, wb_dat_i[15:0],
                    wb_sel_i[1:0]);
            end
        end
    end

    // a control write issues one operation; abort stops a running divide
    always_ff @(posedge clk) begin
        if (srst) begin
            op_code <= op_add;
            byte_mode <= 1'b0;
            lit5 <= 5'h00;
            go <= 1'b0;
            div_abort <= 1'b0;
        end else begin
            go <= 1'b0;
            div_abort <= ctrl_wr && wb_sel_i[3] && wb_dat_i[`ALU_CTRL_ABORT];
            if (ctrl_wr && wb_sel_i[0] && !div_busy &&
                !(wb_sel_i[3] && wb_dat_i[`ALU_CTRL_ABORT])) begin
                op_code <= alu_op_t'(wb_dat_i[4:0]);
                byte_mode <= wb_dat_i[`ALU_CTRL_BYTE];
                lit5 <= wb_dat_i[`ALU_CTRL_LIT +: 5];
                go <= 1'b1;
            end
        end
    end

    // adder: subtract adds the inverted operand, so carry reads as no borrow
    always_comb begin
        opnd_a = dividend_reg_pair[15:0];
        opnd_b = divisor_reg;
        is_sub = (op_code == op_sub) || (op_code == op_subb);
        cin = ((op_code == op_addc) || (op_code == op_subb))
            ? alu_status_reg[`ALU_ST_CARRY] : is_sub;
        bx = is_sub ? ~opnd_b : opnd_b;
        sum_w = {1'b0, opnd_a} + {1'b0, bx} + {16'h0000, cin};
        sum_b = {1'b0, opnd_a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
        sum_n = {1'b0, opnd_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        car = byte_mode ? sum_b[8] : sum_w[16];
        dcar = byte_mode ? sum_n[4] : sum_b[8];
        ovf = byte_mode
            ? (opnd_a[7] == bx[7]) && (sum_b[7] != opnd_a[7])
            : (opnd_a[15] == bx[15]) && (sum_w[15] != opnd_a[15]);
    end

    // barrel shifter, register operand in and register result out
    always_comb begin
        amt = opnd_b[3:0];
        sx = byte_mode ? {{8{opnd_a[7]}}, opnd_a[7:0]} : opnd_a;
        zx = byte_mode ? {8'h00, opnd_a[7:0]} : opnd_a;
        case (op_code)
            arith_right_shift: shf = 16'($signed(sx) >>> amt);
            left_shift_op: shf = zx << amt;
            default: shf = zx >> amt;
        endcase
    end

    // multiplier operand select; byte mode is unsigned only
    always_comb begin
        mul_a = byte_mode ? {8'h00, opnd_a[7:0]} : opnd_a;
        mul_b = byte_mode ? {8'h00, opnd_b[7:0]} : opnd_b;
        if ((op_code == op_mul_sl) || (op_code == op_mul_ul)) begin
            mul_b = {11'h000, lit5};
        end
        mul_a_sgn = !byte_mode &&
            ((op_code == op_mul_ss) || (op_code == op_mul_sl));
        mul_b_sgn = !byte_mode &&
            ((op_code == op_mul_ss) || (op_code == op_mul_us));
    end

    alu_mul #(
        .W(16)
    ) u_mul (
        .a(mul_a),
        .b(mul_b),
        .a_sgn(mul_a_sgn),
        .b_sgn(mul_b_sgn),
        .prod(prod)
    );

    always_comb begin
        val = opnd_a;
        wr_hi = 1'b0;
        upd_arith = 1'b0;
        upd_nz = 1'b0;
        is_div = 1'b0;
        case (op_code)
            op_add, op_addc, op_sub, op_subb: begin
                val = sum_w[15:0];
                upd_arith = 1'b1;
                upd_nz = 1'b1;
            end
            op_and: begin
                val = opnd_a & opnd_b;
                upd_nz = 1'b1;
            end
            op_ior: begin
                val = opnd_a | opnd_b;
                upd_nz = 1'b1;
            end
            op_xor: begin
                val = opnd_a ^ opnd_b;
                upd_nz = 1'b1;
            end
            arith_right_shift, left_shift_op, logical_right_shift: begin
                val = shf;
                upd_nz = 1'b1;
            end
            op_mul_ss, op_mul_uu, op_mul_us, op_mul_sl, op_mul_ul: begin
                wr_hi = 1'b1;
            end
            op_div_s32, op_div_u32, op_div_s16, op_div_u16: begin
                is_div = 1'b1;
            end
            default: begin
                val = opnd_a;
            end
        endcase
        // byte results other than products replace the low byte only
        res_lo = wr_hi ? prod[15:0]
            : (byte_mode ? {opnd_a[15:8], val[7:0]} : val);
        neg = byte_mode ? val[7] : val[15];
        zero = byte_mode ? (val[7:0] == 8'h00) : (val == 16'h0000);
        sgn_div = (op_code == op_div_s32) || (op_code == op_div_s16);
        wide_div = (op_code == op_div_s32) || (op_code == op_div_u32);
        div_dvd = wide_div ? dividend_reg_pair
            : {{16{sgn_div & opnd_a[15]}}, opnd_a};
    end

    assign div_start = go && is_div;

    alu_div #(
        .W(`ALU_DIV_BITS)
    ) u_div (
        .clk(clk),
        .srst(srst),
        .start(div_start),
        .abort(div_abort),
        .sgn(sgn_div),
        .dividend(div_dvd),
        .divisor(divisor_reg),
        .busy(div_busy),
        .done(div_done),
        .ovf(div_ovf),
        .quo(div_q),
        .rem(div_r)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            quotient_reg <= `ALU_RST_WORD;
            remainder_reg <= `ALU_RST_WORD;
        end else if (div_done) begin
            quotient_reg <= div_q;
            remainder_reg <= div_r;
        end else if (go && (upd_nz || wr_hi)) begin
            quotient_reg <= res_lo;
            if (wr_hi) begin
                remainder_reg <= prod[31:16];
            end
        end
    end

    // flag results beat a software write landing on the same edge
    always_comb begin
        next_status = alu_status_reg;
        if (wr_commit && (wb_adr_i == `ALU_OFS_STAT)) begin
            next_status = lane_merge(alu_status_reg, wb_dat_i[15:0],
                wb_sel_i[1:0]) & `ALU_ST_WMASK;
        end
        if (go && upd_arith) begin
            next_status[`ALU_ST_CARRY] = car;
            next_status[`ALU_ST_OVF] = ovf;
            next_status[`ALU_ST_HALF] = dcar;
        end
        if (go && upd_nz) begin
            next_status[`ALU_ST_NEG] = neg;
            next_status[`ALU_ST_ZERO] = zero;
        end
        if (div_done) begin
            next_status[`ALU_ST_OVF] = div_ovf;
            next_status[`ALU_ST_NEG] = div_q[15];
            next_status[`ALU_ST_ZERO] = (div_q == 16'h0000);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            alu_status_reg <= `ALU_RST_WORD;
        end else begin
            alu_status_reg <= next_status;
        end
    end

    mul_word_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_mul_uu
        |=> {remainder_reg, quotient_reg} == $past({16'h0000, opnd_a}
            * {16'h0000, opnd_b}))
        else $error("unsigned word product wrong");
    mul_signed_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_mul_ss
        |=> $signed({remainder_reg, quotient_reg}) ==
            $past($signed({{16{opnd_a[15]}}, opnd_a})
            * $signed({{16{opnd_b[15]}}, opnd_b})))
        else $error("signed word product wrong");
    mul_lit_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_mul_ul
        |=> {remainder_reg, quotient_reg} == $past({16'h0000, opnd_a}
            * {27'h0000000, lit5}))
        else $error("literal product wrong");
    mul_byte_a: assert property (@(posedge clk) disable iff (srst)
        go && byte_mode && op_code == op_mul_uu
        |=> quotient_reg == $past({8'h00, opnd_a[7:0]} * {8'h00, opnd_b[7:0]})
            && remainder_reg == 16'h0000)
        else $error("byte product wrong");
    add_ovf_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_add
        |=> alu_status_reg[`ALU_ST_OVF] ==
            ($past(opnd_a[15] == opnd_b[15])
            && quotient_reg[15] != $past(opnd_a[15])))
        else $error("add overflow flag wrong");
    sub_borrow_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_sub
        |=> alu_status_reg[`ALU_ST_CARRY] == $past(opnd_a >= opnd_b))
        else $error("subtract borrow wrong");
    digit_carry_a: assert property (@(posedge clk) disable iff (srst)
        go && byte_mode && op_code == op_add
        |=> alu_status_reg[`ALU_ST_HALF] ==
            $past(({1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]}) > 5'h0F))
        else $error("digit carry wrong");
    shift_asr_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == arith_right_shift
        |=> quotient_reg == $past(16'($signed(opnd_a) >>> opnd_b[3:0])))
        else $error("arithmetic shift wrong");
    shift_lsr_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == logical_right_shift
        |=> quotient_reg == $past(opnd_a >> opnd_b[3:0]))
        else $error("logical shift wrong");
    byte_keep_a: assert property (@(posedge clk) disable iff (srst)
        go && byte_mode && upd_nz
        |=> quotient_reg[15:8] == $past(opnd_a[15:8]))
        else $error("byte op touched high byte");
    zero_flag_a: assert property (@(posedge clk) disable iff (srst)
        go && !byte_mode && op_code == op_xor
        |=> alu_status_reg[`ALU_ST_ZERO] == $past(opnd_a == opnd_b))
        else $error("zero flag wrong");
    div_check_a: assert property (@(posedge clk) disable iff (srst)
        div_done && !div_ovf && op_code == op_div_u16
        |=> {16'h0000, quotient_reg} * $past({16'h0000, divisor_reg})
            + {16'h0000, remainder_reg}
            == $past({16'h0000, dividend_reg_pair[15:0]}))
        else $error("divide result inconsistent");
endmodule : alu_top
`default_nettype wire

// *** testbench/alu_cpu_model.sv ***
// alu_cpu_model.sv: issuing side of the alu, a wishbone master
// assumes a slave that acks each request once
`timescale 1ns/100ps
`default_nettype none
module alu_cpu_model (
    input wire logic clk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] wdat,
    output logic tmo
);
    initial {cyc, stb, we, adr, sel, wdat, tmo} = '0;
    // one classic cycle, held until ack is sampled high or 50 cycles pass
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        tmo <= tmo | (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        wdat <= ~d;
    endtask : xfer
endmodule : alu_cpu_model
`default_nettype wire

// *** testbench/test_cpu_alu_mul_div_shift.sv ***
// test_cpu_alu_mul_div_shift.sv: self-checking bench for alu_top
// assumes alu_cpu_model issues every bus cycle
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.svh"
module test_cpu_alu_mul_div_shift;
    import alu_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc, stb, we, ack, tmo;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] st;
    int n_mismatch = 0;
    int num_checks = 0;
    alu_top alu_top_i (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .alu_status_reg(st));
    alu_cpu_model alu_cpu_model_i (.clk(clk), .ack(ack), .rdat(rdat),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .wdat(wdat), .tmo(tmo));
    initial forever #10 clk = ~clk;
    task automatic print_verdict;
        if (tmo === 1'b1) n_mismatch++;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        alu_cpu_model_i.xfer(1'b1, a, 4'h7, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        alu_cpu_model_i.xfer(1'b0, a, 4'h7, 32'h0, q);
    endtask : rd
    // issue one single-cycle op and let its result settle
    task automatic run(input alu_op_t op, input logic byt,
        input logic [15:0] a, input logic [15:0] b, input logic [4:0] lit);
        wr(`ALU_OFS_OPA_LO, {16'h0, a});
        wr(`ALU_OFS_OPB, {16'h0, b});
        wr(`ALU_OFS_CTRL, {11'h0, lit, 7'h0, byt, 3'h0, op});
        repeat (2) @(posedge clk);
    endtask : run
    task automatic t_reset;
        rd(`ALU_OFS_STAT);
        chk("status", q, 32'h0);
        chk("status port", {16'h0, st}, 32'h0);
        rd(8'h1C);
        chk("unmapped", q, 32'h0);
        alu_cpu_model_i.xfer(1'b1, `ALU_OFS_OPB, 4'h2, 32'h0000_ABCD, q);
        rd(`ALU_OFS_OPB);
        chk("lane", q, 32'h0000_AB00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_alu;
        alu_op_t ops[13] = '{op_add, op_sub, op_sub, op_addc, op_subb,
            op_add, op_sub, op_and, op_ior, op_xor, arith_right_shift,
            left_shift_op, logical_right_shift};
        logic [63:0] rw[13] = '{64'h7FFF_0001_8000_010C,
            64'h0000_0001_FFFF_0008, 64'h0005_0003_0002_0101,
            64'h0001_0001_0003_0000, 64'h0005_0003_0001_0101,
            64'h12F8_0008_1200_0103, 64'h8000_0001_7FFF_0005,
            64'hF0F0_0FF0_00F0_0005, 64'hF0F0_0FF0_FFF0_000D,
            64'hF0F0_F0F0_0000_0007, 64'h8001_000F_FFFF_000D,
            64'h8001_000F_8000_000D, 64'h8001_000F_0001_0005};
        for (int k = 0; k < 13; k++) begin
            run(ops[k], k == 5, rw[k][63:48], rw[k][47:32], 5'h0);
            rd(`ALU_OFS_RES_LO);
            chk("res", q, {16'h0, rw[k][31:16]});
            chk("flg", {16'h0, st}, {16'h0, rw[k][15:0]});
        end
        $display("alu test done");
    endtask : t_alu
    task automatic t_mul;
        alu_op_t ops[6] = '{op_mul_ss, op_mul_uu, op_mul_us, op_mul_sl,
            op_mul_ul, op_mul_uu};
        logic [31:0] p[6] = '{32'h0000_0001, 32'hFFFE_0001, 32'hFFFF_0001,
            32'hFFFF_FFE1, 32'h001E_FFE1, 32'h0000_FE01};
        for (int k = 0; k < 6; k++) begin
            run(ops[k], k == 5, 16'hFFFF, 16'hFFFF, 5'h1F);
            rd(`ALU_OFS_RES_LO);
            chk("prod lo", q, {16'h0, p[k][15:0]});
            rd(`ALU_OFS_RES_HI);
            chk("prod hi", q, {16'h0, p[k][31:16]});
            chk("flg", {16'h0, st}, 32'h0005);
        end
        $display("multiply test done");
    endtask : t_mul
    task automatic t_div;
        alu_op_t ops[5] = '{op_div_s32, op_div_u32, op_div_s16,
            op_div_u16, op_div_u16};
        logic [95:0] rw[5] = '{96'hFFFF_FF9C_0007_FFF2_FFFE_0008,
            96'h0001_0000_0003_5555_0001_0000,
            96'h0000_FF9C_0007_FFF2_FFFE_0008,
            96'h0000_0005_0000_0000_0000_0004,
            96'h0000_FF9C_0007_2484_0000_0000};
        logic [15:0] m;
        int n;
        for (int k = 0; k < 5; k++) begin
            m = (k == 3) ? 16'h0004 : 16'hFFFF;
            wr(`ALU_OFS_STAT, 32'h0);
            wr(`ALU_OFS_OPA_HI, {16'h0, rw[k][95:80]});
            wr(`ALU_OFS_OPA_LO, {16'h0, rw[k][79:64]});
            wr(`ALU_OFS_OPB, {16'h0, rw[k][63:48]});
            wr(`ALU_OFS_CTRL, {27'h0, ops[k]});
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (n < 30 && (rw[k][15:0] == 16'h0 ||
                (st & m) !== rw[k][15:0]));
            if (rw[k][15:0] != 16'h0)
                chk("cycles", n, `ALU_DIV_CYCLES + 1);
            chk("flg", {16'h0, st & m}, {16'h0, rw[k][15:0]});
            if (k != 3) begin
                rd(`ALU_OFS_RES_LO);
                chk("quo", q, {16'h0, rw[k][47:32]});
                rd(`ALU_OFS_RES_HI);
                chk("rem", q, {16'h0, rw[k][31:16]});
            end
        end
        $display("divide test done");
    endtask : t_div
    task automatic t_abort;
        wr(`ALU_OFS_CTRL, {27'h0, op_div_u16});
        repeat (3) @(posedge clk);
        rd(`ALU_OFS_STAT);
        chk("busy", {31'h0, q[16]}, 32'h1);
        wr(`ALU_OFS_OPA_LO, 32'h1234);
        alu_cpu_model_i.xfer(1'b1, `ALU_OFS_CTRL, 4'h8, 32'h8000_0000, q);
        repeat (3) @(posedge clk);
        rd(`ALU_OFS_STAT);
        chk("idle", {31'h0, q[16]}, 32'h0);
        rd(`ALU_OFS_OPA_LO);
        chk("opa kept", q, 32'h0000_FF9C);
        rd(`ALU_OFS_RES_LO);
        chk("quo kept", q, 32'h0000_2484);
        wr(`ALU_OFS_CTRL, {27'h0, op_div_u16});
        repeat (3) @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(`ALU_OFS_STAT);
        chk("reset stat", q, 32'h0);
        $display("abort test done");
    endtask : t_abort
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_alu;
        t_mul;
        t_div;
        t_abort;
        print_verdict;
    end
    // the tests need well under 2000 cycles
    initial begin
        #(20 * 5000);
        n_mismatch++;
        print_verdict;
    end
endmodule : test_cpu_alu_mul_div_shift
`default_nettype wire
